//--- hdl/fnsl_map.vh
// Overview of operation
// - NOT_ACTIVE keeps the green indicator dark.
// - Managing node: no frame before timeout moves to PRE_OPERATIONAL_1.
// - Managing node: traffic before timeout means the managing function never starts.
// - Controlled node: no frame before timeout moves to BASIC_ETHERNET.
// - Controlled node: traffic before timeout moves to PRE_OPERATIONAL_1.
// - BASIC_ETHERNET runs plain Ethernet, green flickers at about 10 Hz.
// - Managing node leaves BASIC_ETHERNET only through interface reset.
// - Controlled node in BASIC_ETHERNET moves to PRE_OPERATIONAL_1 on traffic.
// - PRE_OPERATIONAL_1 shows a single flash about once per second.
// - Managing node in PRE_OPERATIONAL_1 runs reduced cycle only, no cyclic traffic.
// - Controlled node in PRE_OPERATIONAL_1 takes configuration, advances on SoC.
// - Controlled node in pre-operational or ready states lights red on manager failure.
// - PRE_OPERATIONAL_2 shows a double flash about once per second.
// - Managing node in PRE_OPERATIONAL_2 starts cyclic traffic, configures nodes, ignores inputs.
// - Controlled node in PRE_OPERATIONAL_2 moves to READY_TO_OPERATE on manager command.
// - READY_TO_OPERATE shows a triple flash about once per second.
// - Managing node in READY_TO_OPERATE runs cyclic traffic, discards received process data.
// - Controlled node in READY_TO_OPERATE sends mapped data, does not evaluate inputs.
// - OPERATIONAL keeps green steady on, mapping active, inputs evaluated.
// - STOPPED blinks green with equal phases at about 2.5 Hz.
// - Managing node never enters STOPPED.
// - Controlled node in STOPPED drives no data, enters and leaves only on command.
`ifndef FNSL_MAP_VH
`define FNSL_MAP_VH
// node states
`define FNSL_ST_NOT_ACTIVE 3'h0
`define FNSL_ST_BASIC_ETH 3'h1
`define FNSL_ST_PREOP1 3'h2
`define FNSL_ST_PREOP2 3'h3
`define FNSL_ST_READY 3'h4
`define FNSL_ST_OPER 3'h5
`define FNSL_ST_STOPPED 3'h6
// manager commands
`define FNSL_CMD_NONE 3'h0
`define FNSL_CMD_READY 3'h1
`define FNSL_CMD_OPER 3'h2
`define FNSL_CMD_STOP 3'h3
`define FNSL_CMD_PREOP2 3'h4
// timing: tick period in ns and cycles at 100 ns clock
`define FNSL_CLK_NS 100
`define FNSL_TICK_NS 50000000
`define FNSL_TICK_CYC (`FNSL_TICK_NS / `FNSL_CLK_NS)
// pattern lengths in ticks of 50 ms
`define FNSL_FLICKER_TICKS 1
`define FNSL_BLINK_TICKS 4
`define FNSL_FLASH_ON_TICKS 2
`define FNSL_FLASH_GAP_TICKS 2
`define FNSL_FLASH_PERIOD_TICKS 20
// default frame timeout in ms
`define FNSL_TIMEOUT_MS 1000
`define FNSL_TIMEOUT_TICKS (`FNSL_TIMEOUT_MS * 1000000 / `FNSL_TICK_NS)
`endif

//--- hdl/fnsl_sync3.v
`timescale 1ns/1ps
// three-stage input synchroniser; output changes once stages two and three agree
module fnsl_sync3 (
   input wire clk_i,
   input wire rstn_i,
   input wire d_i,
   output reg q_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // s1 is read only by s2 to keep metastability away from logic
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_o <= 1'b0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_o <= s3_q;
         end
      end
   end
endmodule

//--- hdl/fnsl_node.v
`timescale 1ns/1ps
`include "fnsl_map.vh"
// node state sequencer and green status pattern generator
module fnsl_node #(
   parameter TICK_CYC = `FNSL_TICK_CYC,
   parameter TIMEOUT_TICKS = `FNSL_TIMEOUT_TICKS
) (
   input wire clk_i,
   input wire rstn_i,
   input wire mn_mode_i,
   input wire frame_seen_i,
   input wire soc_seen_i,
   input wire mn_lost_i,
   input wire [2:0] cmd_i,
   input wire cmd_valid_i,
   output reg [2:0] state_o,
   output reg green_o,
   output reg red_o,
   output reg mn_active_o,
   output reg cyclic_en_o,
   output reg rx_eval_o,
   output reg tx_pdo_o,
   output reg eth_only_o
);
   localparam [2:0] S_NA = `FNSL_ST_NOT_ACTIVE;
   localparam [2:0] S_BE = `FNSL_ST_BASIC_ETH;
   localparam [2:0] S_P1 = `FNSL_ST_PREOP1;
   localparam [2:0] S_P2 = `FNSL_ST_PREOP2;
   localparam [2:0] S_RD = `FNSL_ST_READY;
   localparam [2:0] S_OP = `FNSL_ST_OPER;
   localparam [2:0] S_ST = `FNSL_ST_STOPPED;
   localparam [4:0] FL_ON = `FNSL_FLASH_ON_TICKS;
   localparam [4:0] FL_GAP = `FNSL_FLASH_GAP_TICKS;
   localparam [4:0] FL_PER = `FNSL_FLASH_PERIOD_TICKS;
   localparam [4:0] BL_HALF = `FNSL_BLINK_TICKS;
   localparam [4:0] FL_STEP = FL_ON + FL_GAP;

   wire frame_s;
   wire soc_s;
   wire lost_s;
   reg frame_d1_q;
   reg soc_d1_q;
   reg [2:0] st_q;
   reg [2:0] st_d;
   reg [31:0] pre_q;
   reg tick_q;
   reg [15:0] tmo_q;
   reg tmo_done;
   reg mn_q;
   reg mn_block_q;
   reg [4:0] ph_q;
   reg [4:0] bl_q;
   reg bl_lvl_q;
   reg fk_q;
   reg flash_lvl;
   reg [1:0] nflash;
   reg green_d;
   wire frame_rise;
   wire soc_rise;

   // bus indications arrive from the frame receiver, possibly on another clock
   fnsl_sync3 u_sync_frame (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i(frame_seen_i),
      .q_o(frame_s)
   );
   fnsl_sync3 u_sync_soc (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i(soc_seen_i),
      .q_o(soc_s)
   );
   fnsl_sync3 u_sync_lost (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i(mn_lost_i),
      .q_o(lost_s)
   );

   assign frame_rise = frame_s & ~frame_d1_q;
   assign soc_rise = soc_s & ~soc_d1_q;

   // shared prescaled tick feeds timeout and all patterns
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         pre_q <= 32'h0;
         tick_q <= 1'b0;
         frame_d1_q <= 1'b0;
         soc_d1_q <= 1'b0;
      end else begin
         frame_d1_q <= frame_s;
         soc_d1_q <= soc_s;
         tick_q <= 1'b0;
         if (pre_q >= TICK_CYC - 1) begin
            pre_q <= 32'h0;
            tick_q <= 1'b1;
         end else begin
            pre_q <= pre_q + 32'h1;
         end
      end
   end

   // role is sampled from reset release until the first tick, then held, so it cannot change later in the run
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         mn_q <= 1'b0;
         tmo_q <= 16'h0;
      end else begin
         if (st_q == S_NA && tmo_q == 16'h0) begin
            mn_q <= mn_mode_i;
         end
         if (st_q != S_NA) begin
            tmo_q <= 16'h0;
         end else if (tick_q && tmo_q != 16'hffff) begin
            tmo_q <= tmo_q + 16'h1;
         end
      end
   end

   // a manager that hears another node before the timeout stays silent until reset
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         mn_block_q <= 1'b0;
      end else if (st_q == S_NA && mn_q && frame_rise) begin
         mn_block_q <= 1'b1;
      end
   end

   // whole ticks only; prescaler and window both start at reset release, so the window is exact
   always @* begin
      tmo_done = (tmo_q >= TIMEOUT_TICKS[15:0]);
   end

   // node state sequencing
   always @* begin
      st_d = st_q;
      case (st_q)
         S_NA: begin
            if (mn_q) begin
               // traffic before timeout: manager stays inactive for good
               if (frame_rise) begin
                  st_d = S_NA;
               end else if (tmo_done && !mn_block_q) begin
                  st_d = S_P1;
               end
            end else begin
               if (frame_rise) begin
                  st_d = S_P1;
               end else if (tmo_done) begin
                  st_d = S_BE;
               end
            end
         end
         S_BE: begin
            // the manager only leaves through reset
            if (!mn_q && frame_rise) begin
               st_d = S_P1;
            end
         end
         S_P1: begin
            if (!mn_q && soc_rise) begin
               st_d = S_P2;
            end else if (!mn_q && cmd_valid_i && cmd_i == `FNSL_CMD_STOP) begin
               st_d = S_ST;
            end else if (mn_q && cmd_valid_i && cmd_i == `FNSL_CMD_PREOP2) begin
               // the manager's own software ends reduced cycle and starts cyclic traffic
               st_d = S_P2;
            end
         end
         S_P2: begin
            if (!mn_q && cmd_valid_i) begin
               if (cmd_i == `FNSL_CMD_READY) begin
                  st_d = S_RD;
               end else if (cmd_i == `FNSL_CMD_STOP) begin
                  st_d = S_ST;
               end
            end else if (mn_q && cmd_valid_i && cmd_i == `FNSL_CMD_READY) begin
               st_d = S_RD;
            end
         end
         S_RD: begin
            // operate is open to both roles
            if (cmd_valid_i && cmd_i == `FNSL_CMD_OPER) begin
               st_d = S_OP;
            end else if (!mn_q && cmd_valid_i && cmd_i == `FNSL_CMD_STOP) begin
               st_d = S_ST;
            end
         end
         S_OP: begin
            // stop is refused for the manager
            if (!mn_q && cmd_valid_i && cmd_i == `FNSL_CMD_STOP) begin
               st_d = S_ST;
            end
         end
         S_ST: begin
            if (cmd_valid_i && cmd_i == `FNSL_CMD_PREOP2) begin
               st_d = S_P2;
            end
         end
         default: begin
            st_d = S_NA;
         end
      endcase
   end

   // state register
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         st_q <= S_NA;
      end else begin
         st_q <= st_d;
      end
   end

   // pattern phase counters; restart on state change so a pattern opens cleanly
   // a tick on the change edge is dropped; the prescaler runs on, so the first phase may run up to one tick short
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         ph_q <= 5'h0;
         bl_q <= 5'h0;
         bl_lvl_q <= 1'b0;
         fk_q <= 1'b0;
      end else if (st_d != st_q) begin
         ph_q <= 5'h0;
         bl_q <= 5'h0;
         bl_lvl_q <= 1'b1;
         fk_q <= 1'b1;
      end else if (tick_q) begin
         fk_q <= ~fk_q;
         if (ph_q == FL_PER - 5'h1) begin
            ph_q <= 5'h0;
         end else begin
            ph_q <= ph_q + 5'h1;
         end
         if (bl_q == BL_HALF - 5'h1) begin
            bl_q <= 5'h0;
            bl_lvl_q <= ~bl_lvl_q;
         end else begin
            bl_q <= bl_q + 5'h1;
         end
      end
   end

   // n flashes of fixed on-time and gap, then the rest of the period is dark
   always @* begin
      // short flashes leave a dark tail longer than the gap even after the third one
      nflash = 2'h1;
      if (st_q == S_P2) begin
         nflash = 2'h2;
      end else if (st_q == S_RD) begin
         nflash = 2'h3;
      end
      flash_lvl = 1'b0;
      if (ph_q < FL_ON) begin
         flash_lvl = 1'b1;
      end else if (nflash >= 2'h2 && ph_q >= FL_STEP && ph_q < FL_STEP + FL_ON) begin
         flash_lvl = 1'b1;
      end else if (nflash == 2'h3 && ph_q >= FL_STEP + FL_STEP &&
                   ph_q < FL_STEP + FL_STEP + FL_ON) begin
         flash_lvl = 1'b1;
      end
   end

   // green pattern per state
   always @* begin
      case (st_q)
         S_NA: green_d = 1'b0;
         S_BE: green_d = fk_q;
         S_P1: green_d = flash_lvl;
         S_P2: green_d = flash_lvl;
         S_RD: green_d = flash_lvl;
         S_OP: green_d = 1'b1;
         S_ST: green_d = bl_lvl_q;
         default: green_d = 1'b0;
      endcase
   end

   // registered outputs and communication enables
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         state_o <= S_NA;
         green_o <= 1'b0;
         red_o <= 1'b0;
         mn_active_o <= 1'b0;
         cyclic_en_o <= 1'b0;
         rx_eval_o <= 1'b0;
         tx_pdo_o <= 1'b0;
         eth_only_o <= 1'b0;
      end else begin
         state_o <= st_q;
         green_o <= green_d;
         // a lost manager is only meaningful for a controlled node
         red_o <= !mn_q && lost_s &&
                  (st_q == S_P1 || st_q == S_P2 || st_q == S_RD);
         mn_active_o <= mn_q && st_q != S_NA && st_q != S_BE;
         // the manager opens cyclic traffic in P2, a controlled node joins from ready
         cyclic_en_o <= (st_q == S_P2 && mn_q) || st_q == S_RD ||
                        st_q == S_OP;
         rx_eval_o <= st_q == S_OP;
         tx_pdo_o <= st_q == S_RD || st_q == S_OP;
         eth_only_o <= st_q == S_BE;
      end
   end
endmodule

//--- sim/fnsl_node_sva.sv
`timescale 1ns/1ps
module fnsl_node_chk (
   input wire clk_i,
   input wire rstn_i,
   input wire mn_mode_i,
   input wire [2:0] cmd_i,
   input wire cmd_valid_i,
   input wire [2:0] state_o,
   input wire green_o,
   input wire red_o,
   input wire cyclic_en_o,
   input wire rx_eval_o,
   input wire eth_only_o
);
   reg mn_q;
   // role is fixed while reset is held, so latch it there
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         mn_q <= mn_mode_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence go_cmd(c, s);
      cmd_valid_i && cmd_i == c && state_o == s;
   endsequence
   sequence left_stop;
      state_o == 3'h6 ##1 state_o != 3'h6;
   endsequence
   a_idle_dark: assert property (state_o == 3'h0 |-> !green_o)
      else $error("green lit while not active");
   a_eth_mode: assert property (eth_only_o == (state_o == 3'h1))
      else $error("ethernet flag out of step with state");
   a_mn_eth_stuck: assert property (mn_q && state_o == 3'h1 |=> state_o == 3'h1)
      else $error("manager left plain ethernet");
   a_p1_no_cyclic: assert property (state_o == 3'h2 |-> !cyclic_en_o)
      else $error("cyclic traffic in first preop state");
   a_red_cn_only: assert property (red_o |-> !mn_q && state_o inside {[3'h2:3'h4]})
      else $error("red lit outside allowed states");
   a_ready_cmd: assert property (go_cmd(3'h1, 3'h3) |-> ##2 state_o == 3'h4)
      else $error("ready command not taken");
   a_oper_cmd: assert property (go_cmd(3'h2, 3'h4) |-> ##2 state_o == 3'h5)
      else $error("operate command not taken");
   a_oper_lit: assert property (state_o == 3'h5 |-> green_o && rx_eval_o)
      else $error("operational without steady green");
   a_mn_p2_cyc: assert property (mn_q && state_o == 3'h3 |-> cyclic_en_o && !rx_eval_o)
      else $error("manager preop2 traffic wrong");
   a_rd_no_eval: assert property (state_o == 3'h4 |-> !rx_eval_o)
      else $error("inputs evaluated in ready");
   a_mn_no_stop: assert property (mn_q |-> state_o != 3'h6)
      else $error("manager stopped");
   a_stop_cmd: assert property (!mn_q && cmd_valid_i && cmd_i == 3'h3
      && state_o inside {[3'h2:3'h5]} |-> ##2 state_o == 3'h6)
      else $error("stop command not taken");
   a_stop_leave: assert property (left_stop |-> $past(cmd_valid_i, 2)
      && $past(cmd_i, 2) == 3'h4)
      else $error("stopped left without command");
endmodule
bind fnsl_node fnsl_node_chk chk (.clk_i(clk_i), .rstn_i(rstn_i), .mn_mode_i(mn_mode_i),
   .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .state_o(state_o), .green_o(green_o),
   .red_o(red_o), .cyclic_en_o(cyclic_en_o), .rx_eval_o(rx_eval_o),
   .eth_only_o(eth_only_o));

//--- sim/fnsl_net.sv
`timescale 1ns/1ps
module fnsl_net (
   input wire clk_i,
   output reg frame_o,
   output reg soc_o,
   output reg lost_o,
   output reg [2:0] cmd_o,
   output reg cmd_valid_o
);
   // quiet network at start
   initial begin
      frame_o = 0;
      soc_o = 0;
      lost_o = 0;
      cmd_o = 3'h0;
      cmd_valid_o = 0;
   end
   // four cycles so the three-flop synchroniser cannot miss it
   task frame;
      begin
         @(negedge clk_i) frame_o = 1;
         repeat (4) @(negedge clk_i);
         frame_o = 0;
      end
   endtask
   // start of cycle seen by a controlled node
   task soc;
      begin
         @(negedge clk_i) soc_o = 1;
         repeat (4) @(negedge clk_i);
         soc_o = 0;
      end
   endtask
   task lost(input v);
      @(negedge clk_i) lost_o = v;
   endtask
   // one-cycle strobe; code is scrambled once invalid, as a real sender gives no hold
   task command(input [2:0] c);
      begin
         @(negedge clk_i) cmd_o = c;
         cmd_valid_o = 1;
         @(negedge clk_i) cmd_valid_o = 0;
         cmd_o = ~c;
      end
   endtask
endmodule

//--- sim/fieldbus_node_state_led_tb.sv
`timescale 1ns/1ps
module fieldbus_node_state_led_tb;
   reg clk_i = 0;
   reg rstn_i = 0;
   reg mn_mode_i = 0;
   wire frame;
   wire soc;
   wire lost;
   wire cv;
   wire green;
   wire red;
   wire mna;
   wire cyc;
   wire rxe;
   wire txp;
   wire eth;
   wire [2:0] cmd;
   wire [2:0] st;
   integer error_cnt = 0;
   integer n_compared = 0;
   always #50 clk_i = ~clk_i;
   // short tick and timeout keep the run brief: tick 10 cycles, timeout 30
   fnsl_node #(.TICK_CYC(10), .TIMEOUT_TICKS(3)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .mn_mode_i(mn_mode_i), .frame_seen_i(frame), .soc_seen_i(soc), .mn_lost_i(lost),
      .cmd_i(cmd), .cmd_valid_i(cv), .state_o(st), .green_o(green), .red_o(red),
      .mn_active_o(mna), .cyclic_en_o(cyc), .rx_eval_o(rxe), .tx_pdo_o(txp),
      .eth_only_o(eth));
   fnsl_net net (.clk_i(clk_i), .frame_o(frame), .soc_o(soc), .lost_o(lost),
      .cmd_o(cmd), .cmd_valid_o(cv));
   task results;
      begin
         $display("compared %0d errors %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input e, input g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s exp %b got %b", nm, e, g);
         end
      end
   endtask
   task chk_n(input string nm, input [7:0] e, input [7:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
         end
      end
   endtask
   task rst(input m);
      begin
         @(negedge clk_i) rstn_i = 0;
         mn_mode_i = m;
         repeat (16) @(negedge clk_i);
         rstn_i = 1;
      end
   endtask
   // bounded wait for a state; running out ends the run
   task wst(input [2:0] e);
      integer i;
      begin
         for (i = 0; i < 80 && st !== e; i = i + 1) @(negedge clk_i);
         chk_n("state", {5'h0, e}, {5'h0, st});
         if (st !== e) results;
      end
   endtask
   // rising edges of green over a window of whole pattern periods
   task rises(input integer n, input [7:0] e);
      integer i, c;
      reg p;
      begin
         c = 0;
         p = green;
         for (i = 0; i < n; i = i + 1) begin
            @(negedge clk_i);
            if (green && !p) c = c + 1;
            p = green;
         end
         chk_n("flashes", e, c[7:0]);
      end
   endtask
   task sc_cn_path;
      begin
         rst(0);
         chk("green", 0, green);
         repeat (20) @(negedge clk_i);
         chk_n("state", 8'h0, {5'h0, st});
         wst(3'h1);
         chk("eth", 1, eth);
         rises(200, 10);
         net.frame;
         wst(3'h2);
         rises(200, 1);
         net.soc;
         wst(3'h3);
         rises(200, 2);
         net.command(3'h1);
         wst(3'h4);
         chk("tx", 1, txp);
         chk("eval", 0, rxe);
         rises(200, 3);
         net.command(3'h2);
         wst(3'h5);
         rises(200, 0);
         net.command(3'h3);
         wst(3'h6);
         chk("tx", 0, txp);
         rises(400, 5);
         net.command(3'h4);
         wst(3'h3);
      end
   endtask
   task sc_cn_early;
      begin
         rst(0);
         net.frame;
         wst(3'h2);
         net.lost(1);
         repeat (8) @(negedge clk_i);
         chk("red", 1, red);
         net.lost(0);
      end
   endtask
   task sc_mn;
      begin
         rst(1);
         wst(3'h2);
         chk("cyclic", 0, cyc);
         chk("active", 1, mna);
         net.command(3'h4);
         wst(3'h3);
         chk("cyclic", 1, cyc);
         chk("eval", 0, rxe);
         net.command(3'h1);
         wst(3'h4);
         chk("eval", 0, rxe);
         net.command(3'h2);
         wst(3'h5);
         net.command(3'h3);
         net.lost(1);
         repeat (8) @(negedge clk_i);
         chk_n("state", 8'h5, {5'h0, st});
         chk("red", 0, red);
         net.lost(0);
         rst(1);
         net.frame;
         repeat (60) @(negedge clk_i);
         chk_n("state", 8'h0, {5'h0, st});
         chk("active", 0, mna);
         chk("green", 0, green);
      end
   endtask
   initial begin
      sc_cn_path;
      sc_cn_early;
      sc_mn;
      results;
   end
endmodule
